// ### adc_equalizer_fir.sv
// Purpose: Nine-tap equalizing filter with an output FIFO.
// Assumes: Samples and settings arrive on mclk; downstream may stall.
// Notes:   Single-stream modes carry the stream on lane a; lane b then reads zero.
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Output FIFO
module eq_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = adc_equalizer_pkg::FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             wValid,
  output logic                  wReady,
  input  wire logic [WIDTH-1:0] wData,
  output logic                  rValid,
  input  wire logic             rReady,
  output logic [WIDTH-1:0]      rData
);
  localparam int AW = $clog2(DEPTH);
  // Wrap-bit pointers only work for power-of-two depths
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
  logic             doWrite, doRead;

  assign wReady  = (wrPtr_ff[AW] == rdPtr_ff[AW]) || (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]);
  assign rValid  = wrPtr_ff != rdPtr_ff;
  assign rData   = mem[rdPtr_ff[AW-1:0]];
  assign doWrite = wValid && wReady;
  assign doRead  = rValid && rReady;

  always_comb begin
    nxt_wrPtr = doWrite ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = doRead ? rdPtr_ff + 1'b1 : rdPtr_ff;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
    end
  end

  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wrPtr_ff[AW-1:0]] <= wData;
    end
  end
endmodule // eq_fifo

// ============================================================================
// Filter top
module adc_equalizer_fir (
  input  wire logic                           mclk,
  input  wire logic                           resetn,
  input  wire logic [1:0]                     filterModeSelect,
  input  wire logic                           coefShareFlag,
  input  wire logic                           pathMergeFlag,
  input  wire logic [2:0]                     sideWeightSel,
  input  wire adc_equalizer_pkg::coef_set_t   chanACoefRegs,
  input  wire adc_equalizer_pkg::coef_set_t   chanBCoefRegs,
  input  wire logic                           inValid,
  output logic                                inReady,
  input  wire adc_equalizer_pkg::sample_pair_t inSample,
  output logic                                outValid,
  input  wire logic                           outReady,
  output adc_equalizer_pkg::sample_pair_t     outSample,
  output adc_equalizer_pkg::eq_mode_t         activeMode
);
  localparam int W  = adc_equalizer_pkg::SAMPLE_W;
  localparam int N  = adc_equalizer_pkg::TAPS;
  localparam int AW = adc_equalizer_pkg::ACC_W;
  localparam int FRAC_SHIFT = adc_equalizer_pkg::FRAC_BITS;

  // ==========================================================================
  // Reset release
  logic rstMeta_ff, rstn;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_ff <= 1'b0;
      rstn       <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstn       <= rstMeta_ff;
    end
  end

  // ==========================================================================
  // Mode decode
  adc_equalizer_pkg::eq_mode_t mode;
  always_comb begin
    mode = adc_equalizer_pkg::EQ_BYPASS;
    if (filterModeSelect == adc_equalizer_pkg::MODE_ON) begin
      if (!coefShareFlag && !pathMergeFlag) begin
        mode = adc_equalizer_pkg::EQ_DUAL;
      end else if (coefShareFlag && pathMergeFlag) begin
        mode = adc_equalizer_pkg::EQ_SINGLE;
      end else if (!coefShareFlag && pathMergeFlag) begin
        mode = adc_equalizer_pkg::EQ_VARY;
      end
    end
  end
  assign activeMode = mode;

  // Weight codes above the largest shift are clamped rather than wrapped
  logic [2:0] weight;
  assign weight = (sideWeightSel > adc_equalizer_pkg::WEIGHT_MAX) ? adc_equalizer_pkg::WEIGHT_MAX : sideWeightSel;

  // ==========================================================================
  // Delay lines and sample phase
  logic signed [W-1:0] lineA_ff [N];
  logic signed [W-1:0] lineB_ff [N];
  logic signed [W-1:0] nxt_lineA [N];
  logic signed [W-1:0] nxt_lineB [N];
  logic                lineValid_ff, nxt_lineValid;
  logic                phase_ff, nxt_phase;
  logic                linePhase_ff, nxt_linePhase;
  logic                fifoReady, advance;

  // A stalled FIFO freezes the line, so no sample is dropped or repeated
  assign inReady = !lineValid_ff || fifoReady;
  assign advance = inValid && inReady;

  always_comb begin
    for (int k = 0; k < N; k++) begin
      nxt_lineA[k] = lineA_ff[k];
      nxt_lineB[k] = lineB_ff[k];
    end
    nxt_lineValid = lineValid_ff && !fifoReady;
    // Leaving the alternating mode re-arms set A for the next entry
    nxt_phase     = (mode == adc_equalizer_pkg::EQ_VARY) ? phase_ff : adc_equalizer_pkg::RESET_PHASE;
    nxt_linePhase = linePhase_ff;
    if (advance) begin
      nxt_lineA[0] = inSample.a;
      nxt_lineB[0] = inSample.b;
      for (int k = 1; k < N; k++) begin
        nxt_lineA[k] = lineA_ff[k-1];
        nxt_lineB[k] = lineB_ff[k-1];
      end
      nxt_lineValid = 1'b1;
      nxt_linePhase = phase_ff;
      nxt_phase     = (mode == adc_equalizer_pkg::EQ_VARY) ? !phase_ff : adc_equalizer_pkg::RESET_PHASE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < N; k++) begin
        lineA_ff[k] <= '0;
        lineB_ff[k] <= '0;
      end
      lineValid_ff <= adc_equalizer_pkg::RESET_VALID;
      phase_ff     <= adc_equalizer_pkg::RESET_PHASE;
      linePhase_ff <= adc_equalizer_pkg::RESET_PHASE;
    end else begin
      for (int k = 0; k < N; k++) begin
        lineA_ff[k] <= nxt_lineA[k];
        lineB_ff[k] <= nxt_lineB[k];
      end
      lineValid_ff <= nxt_lineValid;
      phase_ff     <= nxt_phase;
      linePhase_ff <= nxt_linePhase;
    end
  end

  // ==========================================================================
  // Tap arithmetic, rounding only at the output
  function automatic logic signed [W-1:0] fir_out(
    input logic signed [W-1:0]        x [N],
    input adc_equalizer_pkg::coef_set_t c,
    input logic [2:0]                  wsel
  );
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] prod;
    logic signed [AW-FRAC_SHIFT-1:0] q;
    logic signed [AW-FRAC_SHIFT:0]   r;
    logic [adc_equalizer_pkg::FRAC_BITS-1:0] frac;
    logic up;
    acc = '0;
    for (int k = 0; k < N; k++) begin
      if (k == adc_equalizer_pkg::CENTRE_IDX) begin
        prod = AW'(x[k] * c.centre);
      end else begin
        prod = AW'(x[k] * $signed(c.side[k > adc_equalizer_pkg::CENTRE_IDX ? k-1 : k]))
               <<< (adc_equalizer_pkg::WEIGHT_MAX - wsel);
      end
      acc = acc + prod;
    end
    q    = acc[AW-1:FRAC_SHIFT];
    frac = acc[FRAC_SHIFT-1:0];
    // Ties go to the even code so the rounding adds no DC offset
    up   = frac[FRAC_SHIFT-1] && ((frac[FRAC_SHIFT-2:0] != '0) || q[0]);
    r    = {q[AW-FRAC_SHIFT-1], q} + (AW-FRAC_SHIFT+1)'(up);
    if (r > (AW-FRAC_SHIFT+1)'(2 ** (W-1) - 1)) begin
      fir_out = {1'b0, {(W-1){1'b1}}};
    end else if (r < -(AW-FRAC_SHIFT+1)'(2 ** (W-1))) begin
      fir_out = {1'b1, {(W-1){1'b0}}};
    end else begin
      fir_out = r[W-1:0];
    end
  endfunction

  adc_equalizer_pkg::sample_pair_t filtered, pushData;
  logic signed [W-1:0] laneOut [adc_equalizer_pkg::LANES];
  genvar g;
  generate
    for (g = 0; g < adc_equalizer_pkg::LANES; g++) begin : gLane
      adc_equalizer_pkg::coef_set_t laneCoef;
      always_comb begin
        if (g == 0) begin
          laneCoef = (mode == adc_equalizer_pkg::EQ_VARY && linePhase_ff) ? chanBCoefRegs : chanACoefRegs;
          laneOut[g] = fir_out(lineA_ff, laneCoef, weight);
        end else begin
          laneCoef = chanBCoefRegs;
          laneOut[g] = fir_out(lineB_ff, laneCoef, weight);
        end
      end
    end
  endgenerate

  always_comb begin
    filtered.a = laneOut[0];
    filtered.b = (mode == adc_equalizer_pkg::EQ_DUAL) ? laneOut[1] : '0;
    if (mode == adc_equalizer_pkg::EQ_BYPASS) begin
      pushData.a = lineA_ff[0];
      pushData.b = lineB_ff[0];
    end else begin
      pushData = filtered;
    end
  end

  // ==========================================================================
  // Output buffer
  eq_fifo #(
    .WIDTH (2 * W),
    .DEPTH (adc_equalizer_pkg::FIFO_DEPTH)
  ) uFifo (
    .mclk   (mclk),
    .rstn   (rstn),
    .wValid (lineValid_ff),
    .wReady (fifoReady),
    .wData  (pushData),
    .rValid (outValid),
    .rReady (outReady),
    .rData  (outSample)
  );

  // ==========================================================================
  // Checks
  property p_bypass_pass;
    @(posedge mclk) disable iff (!rstn)
    lineValid_ff && mode == adc_equalizer_pkg::EQ_BYPASS |-> pushData.a == lineA_ff[0] && pushData.b == lineB_ff[0];
  endproperty
  a_bypass_pass: assert property (p_bypass_pass) else $error("bypass altered a sample");

  property p_mode_decode;
    @(posedge mclk) disable iff (!rstn)
    filterModeSelect == adc_equalizer_pkg::MODE_OFF |-> activeMode == adc_equalizer_pkg::EQ_BYPASS;
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode 0 did not bypass");

  property p_dual_b_used;
    @(posedge mclk) disable iff (!rstn)
    mode != adc_equalizer_pkg::EQ_DUAL && mode != adc_equalizer_pkg::EQ_BYPASS |-> pushData.b == '0;
  endproperty
  a_dual_b_used: assert property (p_dual_b_used) else $error("lane b active outside dual mode");

  property p_single_lane;
    @(posedge mclk) disable iff (!rstn)
    mode == adc_equalizer_pkg::EQ_SINGLE |-> pushData.a == laneOut[0] && gLane[0].laneCoef == chanACoefRegs;
  endproperty
  a_single_lane: assert property (p_single_lane) else $error("single stream not filtered");

  property p_vary_toggle;
    @(posedge mclk) disable iff (!rstn)
    advance && mode == adc_equalizer_pkg::EQ_VARY ##1 mode == adc_equalizer_pkg::EQ_VARY
      |-> linePhase_ff == $past(phase_ff) && phase_ff != $past(phase_ff);
  endproperty
  a_vary_toggle: assert property (p_vary_toggle) else $error("coefficient set did not alternate");

  property p_weight_range;
    @(posedge mclk) disable iff (!rstn)
    1'b1 |-> weight <= adc_equalizer_pkg::WEIGHT_MAX
      && (sideWeightSel > adc_equalizer_pkg::WEIGHT_MAX || weight == sideWeightSel);
  endproperty
  a_weight_range: assert property (p_weight_range) else $error("weight setting out of range");

  property p_one_out_per_in;
    @(posedge mclk) disable iff (!rstn)
    advance |=> lineValid_ff && lineA_ff[1] == $past(lineA_ff[0]);
  endproperty
  a_one_out_per_in: assert property (p_one_out_per_in) else $error("accepted sample not staged");

  property p_hold_on_stall;
    @(posedge mclk) disable iff (!rstn)
    lineValid_ff && !fifoReady |=> lineValid_ff && $stable(lineA_ff[0]) && $stable(lineB_ff[0]);
  endproperty
  a_hold_on_stall: assert property (p_hold_on_stall) else $error("stalled sample lost");

  c_dual: cover property (@(posedge mclk) disable iff (!rstn) advance && mode == adc_equalizer_pkg::EQ_DUAL);
  c_vary: cover property (@(posedge mclk) disable iff (!rstn) advance && mode == adc_equalizer_pkg::EQ_VARY ##1 advance);
  c_full: cover property (@(posedge mclk) disable iff (!rstn) lineValid_ff && !fifoReady);
  c_single: cover property (@(posedge mclk) disable iff (!rstn) advance && mode == adc_equalizer_pkg::EQ_SINGLE);
endmodule // adc_equalizer_fir

`default_nettype wire

// ### adc_equalizer_pkg.sv
// Purpose: Shared constants and carrier types of the equalizer filter.
// Assumes: One sample clock; coefficients and mode come from registers on the same clock.
// Notes:   Samples are signed two's complement.
package adc_equalizer_pkg;
  // ==========================================================================
  // Widths and counts
  localparam int SAMPLE_W   = 12;
  localparam int CENTRE_W   = 18;
  localparam int SIDE_W     = 12;
  localparam int TAPS       = 9;
  localparam int CENTRE_IDX = 4;
  localparam int ACC_W      = 34;
  localparam int FRAC_BITS  = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int LANES      = 2;
  // ==========================================================================
  // Mode encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON  = 2'h2;
  // Weight code 0 means 2^-10, code 6 means 2^-16
  localparam logic [2:0] WEIGHT_MAX = 3'h6;
  // ==========================================================================
  // Reset values
  localparam logic RESET_PHASE = 1'b0;
  localparam logic RESET_VALID = 1'b0;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    EQ_BYPASS = 2'b00,
    EQ_DUAL   = 2'b01,
    EQ_SINGLE = 2'b11,
    EQ_VARY   = 2'b10
  } eq_mode_t;

  typedef struct packed {
    logic signed [CENTRE_W-1:0]         centre;
    logic [TAPS-2:0][SIDE_W-1:0]        side;
  } coef_set_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] a;
    logic signed [SAMPLE_W-1:0] b;
  } sample_pair_t;
endpackage

// ### eq_sink_model.sv
// Purpose: Downstream sink model for the equalizer output stream.
// Assumes: A sample is taken at a rising edge with outValid and outReady high.
// Notes:   Ready moves at the falling edge; slow halves the drain rate.
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Sink
module eq_sink_model (
  input  wire logic                            mclk,
  input  wire logic                            stall,
  input  wire logic                            slow,
  input  wire logic                            outValid,
  input  wire adc_equalizer_pkg::sample_pair_t outSample,
  output logic                                 outReady
);
  adc_equalizer_pkg::sample_pair_t rxQ[$];
  logic                            tick;
  initial begin
    tick = 1'h0;
    outReady = 1'h0;
  end
  // Slow mode stalls every other cycle to stress the FIFO pointers
  always @(negedge mclk) begin
    tick = ~tick;
    outReady <= !stall && !(slow && tick);
  end
  always @(posedge mclk) begin
    if (outValid === 1'h1 && outReady === 1'h1) begin
      rxQ.push_back(outSample);
    end
  end
endmodule // eq_sink_model
`default_nettype wire

// ### tb_adc_equalizer_fir.sv
// Purpose: Self-checking bench of the equalizer filter.
// Assumes: Inputs change at the falling edge; the sink model drains the output.
// Notes:   Expected samples come from a reference filter written here.
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Bench top
module tb_adc_equalizer_fir;
  logic                            mclk;
  logic                            resetn;
  logic [1:0]                      filterModeSelect;
  logic                            coefShareFlag;
  logic                            pathMergeFlag;
  logic [2:0]                      sideWeightSel;
  adc_equalizer_pkg::coef_set_t    chanACoefRegs;
  adc_equalizer_pkg::coef_set_t    chanBCoefRegs;
  logic                            inValid;
  logic                            inReady;
  adc_equalizer_pkg::sample_pair_t inSample;
  logic                            outValid;
  logic                            outReady;
  adc_equalizer_pkg::sample_pair_t outSample;
  adc_equalizer_pkg::eq_mode_t     activeMode;
  logic                            stall;
  logic                            slow;
  int                              nErrors;
  int                              checks;
  int                              phase;
  int                              ha[9];
  int                              hb[9];
  adc_equalizer_pkg::sample_pair_t expQ[$];
  int                              tbl[8] = '{2047, -2048, 1, -1, 1000, -1500, 0, 613};

  adc_equalizer_fir dut_u (.mclk(mclk), .resetn(resetn), .filterModeSelect(filterModeSelect),
    .coefShareFlag(coefShareFlag), .pathMergeFlag(pathMergeFlag), .sideWeightSel(sideWeightSel),
    .chanACoefRegs(chanACoefRegs), .chanBCoefRegs(chanBCoefRegs), .inValid(inValid), .inReady(inReady),
    .inSample(inSample), .outValid(outValid), .outReady(outReady), .outSample(outSample),
    .activeMode(activeMode));
  eq_sink_model sink_u (.mclk(mclk), .stall(stall), .slow(slow), .outValid(outValid),
    .outSample(outSample), .outReady(outReady));

  initial mclk = 1'h0;
  always #50 mclk = ~mclk;

  // ==========================================================================
  // Reference model
  function automatic adc_equalizer_pkg::eq_mode_t dec(logic [1:0] m, logic s, logic g);
    if (m != 2'h2) return adc_equalizer_pkg::EQ_BYPASS;
    case ({s, g})
      2'h0: return adc_equalizer_pkg::EQ_DUAL;
      2'h3: return adc_equalizer_pkg::EQ_SINGLE;
      2'h1: return adc_equalizer_pkg::EQ_VARY;
      default: return adc_equalizer_pkg::EQ_BYPASS;
    endcase
  endfunction

  // Full precision sum, one convergent rounding at the end, then saturation
  function automatic int fir(input int h[9], input adc_equalizer_pkg::coef_set_t c);
    longint acc;
    longint q;
    longint cf;
    int     sh;
    acc = 0;
    sh = 6 - ((sideWeightSel > 3'h6) ? 6 : int'(sideWeightSel));
    for (int k = 0; k < 9; k++) begin
      if (k == 4) cf = longint'($signed(c.centre));
      else cf = longint'($signed(c.side[k < 4 ? k : k - 1])) <<< sh;
      acc += h[k] * cf;
    end
    q = acc >>> 16;
    if ((acc - (q <<< 16)) > 32768 || ((acc - (q <<< 16)) == 32768 && q[0])) q++;
    return (q > 2047) ? 2047 : ((q < -2048) ? -2048 : int'(q));
  endfunction

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
    checks++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic set_mode(input logic [1:0] m, input logic s, input logic g);
    filterModeSelect = m;
    coefShareFlag = s;
    pathMergeFlag = g;
    phase = 0;
    #1;
    check("activeMode", dec(m, s, g), activeMode);
    @(negedge mclk);
  endtask

  // Holds the request until taken or the limit runs out; the caller lowers inValid
  task automatic offer(input int a, input int b, input int lim, output bit ok);
    adc_equalizer_pkg::sample_pair_t e;
    inValid <= 1'h1;
    inSample <= {12'(a), 12'(b)};
    ok = 0;
    for (int i = 0; i < lim && !ok; i++) begin
      #1;
      ok = (inReady === 1'h1);
      @(negedge mclk);
    end
    if (ok) begin
      for (int k = 8; k > 0; k--) begin
        ha[k] = ha[k-1];
        hb[k] = hb[k-1];
      end
      ha[0] = a;
      hb[0] = b;
      e = {12'(a), 12'(b)};
      case (dec(filterModeSelect, coefShareFlag, pathMergeFlag))
        adc_equalizer_pkg::EQ_DUAL: e = {12'(fir(ha, chanACoefRegs)), 12'(fir(hb, chanBCoefRegs))};
        adc_equalizer_pkg::EQ_SINGLE: e = {12'(fir(ha, chanACoefRegs)), 12'h000};
        adc_equalizer_pkg::EQ_VARY: begin
          e = {12'(fir(ha, phase ? chanBCoefRegs : chanACoefRegs)), 12'h000};
          phase ^= 1;
        end
        default: ;
      endcase
      expQ.push_back(e);
    end
  endtask

  task automatic drain();
    for (int i = 0; i < 300 && sink_u.rxQ.size() < expQ.size(); i++) @(negedge mclk);
    check("count", expQ.size(), sink_u.rxQ.size());
    foreach (expQ[i]) if (i < sink_u.rxQ.size()) check("outSample", expQ[i], sink_u.rxQ[i]);
    expQ.delete();
    sink_u.rxQ.delete();
  endtask

  task automatic stream(input int n, input int base);
    bit ok;
    for (int i = 0; i < n; i++) offer(tbl[(i + base) % 8], tbl[(3 * i + base + 1) % 8], 50, ok);
    inValid <= 1'h0;
    drain();
  endtask

  // Pushes eight zeros, clearing all taps but the oldest; outputs that still hold older history are dropped
  task automatic flush();
    bit ok;
    for (int i = 0; i < 8; i++) offer(0, 0, 50, ok);
    inValid <= 1'h0;
    repeat (30) @(negedge mclk);
    expQ.delete();
    sink_u.rxQ.delete();
    foreach (ha[k]) ha[k] = 0;
    foreach (hb[k]) hb[k] = 0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_decode();
    for (int i = 0; i < 16; i++) set_mode(2'(i >> 2), i[1], i[0]);
    $display("decode done, %0d mismatches", nErrors);
  endtask

  task automatic t_bypass();
    set_mode(2'h0, 1'h1, 1'h1);
    stream(12, 0);
    set_mode(2'h3, 1'h0, 1'h0);
    stream(8, 2);
    set_mode(2'h2, 1'h1, 1'h0);
    stream(8, 5);
    $display("bypass done, %0d mismatches", nErrors);
  endtask

  task automatic t_filters();
    sideWeightSel <= 3'h3;
    set_mode(2'h2, 1'h0, 1'h0);
    flush();
    stream(24, 3);
    set_mode(2'h2, 1'h0, 1'h1);
    flush();
    stream(24, 7);
    set_mode(2'h2, 1'h1, 1'h1);
    flush();
    for (int w = 0; w < 8; w++) begin
      sideWeightSel <= 3'(w);
      @(negedge mclk);
      stream(10, w);
    end
    $display("filters done, %0d mismatches", nErrors);
  endtask

  task automatic t_full();
    bit ok;
    int n;
    set_mode(2'h2, 1'h0, 1'h0);
    flush();
    stall <= 1'h1;
    repeat (2) @(negedge mclk);
    n = 0;
    ok = 1;
    while (ok && n < 40) begin
      offer(tbl[n % 8], tbl[(n + 5) % 8], 4, ok);
      n += ok;
    end
    inValid <= 1'h0;
    check("accepted", adc_equalizer_pkg::FIFO_DEPTH + 1, n);
    stall <= 1'h0;
    slow <= 1'h1;
    drain();
    slow <= 1'h0;
    $display("backpressure done, %0d mismatches", nErrors);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence; coefficients are loaded before any filtering
  initial begin
    resetn = 1'h0;
    {filterModeSelect, coefShareFlag, pathMergeFlag, sideWeightSel} = 7'h00;
    chanACoefRegs = {18'h0A000, 12'h7FF, 12'h800, 12'h123, 12'hF00, 12'h040, 12'hFC0, 12'h3A5, 12'h001};
    chanBCoefRegs = {18'h30000, 12'h010, 12'hFF0, 12'h200, 12'hE01, 12'h7FF, 12'h00C, 12'h801, 12'h0FF};
    inValid = 1'h0;
    inSample = 24'h000000;
    {stall, slow} = 2'h0;
    nErrors = 0;
    checks = 0;
    phase = 0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'h1;
    repeat (3) @(negedge mclk);
    t_decode();
    t_bypass();
    t_filters();
    t_full();
    give_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge mclk);
    nErrors++;
    give_verdict();
  end
endmodule // tb_adc_equalizer_fir
`default_nettype wire
